// *** ctm_pkg.sv ***
package ctm_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 10;

    // times in ns; least times round up, longest times round down
    localparam int DOM_TIMEOUT_NS = 1000000;
    localparam int DOM_TIMEOUT_CYC =
        (DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WK_FILTER_NS = 1000;
    localparam int WK_FILTER_CYC =
        (WK_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WK_WINDOW_NS = 1000000;
    localparam int WK_WINDOW_CYC = WK_WINDOW_NS / CLK_PERIOD_NS;
    localparam int RECOVERY_NS = 50000;
    localparam int RECOVERY_CYC =
        (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_SETTLE_NS = 20000;
    localparam int MODE_SETTLE_CYC =
        (MODE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter width, event word and buffer shape
    localparam int CNT_W = 20;
    localparam int EVT_W = 8;
    localparam int EVT_DEPTH = 16;
    localparam int EV_BITS = 5;

    // event bit positions
    localparam int EV_WAKE = 0;
    localparam int EV_DOMTO = 1;
    localparam int EV_UV = 2;
    localparam int EV_TSD = 3;
    localparam int EV_READY = 4;

    typedef enum logic [3:0] {
        ST_PROT = 4'b0001,
        ST_RECOV = 4'b0010,
        ST_STBY = 4'b0100,
        ST_NORM = 4'b1000
    } ctm_mode_t;

    typedef enum logic [3:0] {
        WK_IDLE = 4'b0001,
        WK_DOM1 = 4'b0010,
        WK_REC = 4'b0100,
        WK_DONE = 4'b1000
    } ctm_wake_t;

    localparam ctm_mode_t MODE_RESET = ST_RECOV;

    typedef struct packed {
        ctm_mode_t mode;
        ctm_wake_t wk;
        logic domFault;
        logic txdPrev;
        logic [CNT_W-1:0] domCnt;
        logic filtDom;
        logic [CNT_W-1:0] filtCnt;
        logic [CNT_W-1:0] winCnt;
        logic [CNT_W-1:0] recCnt;
        logic wakeSeen;
        logic tsd;
        logic drvDom;
        logic rxd;
    } ctm_core_t;
endpackage

// *** ctm_fifo_if.sv ***
`timescale 1ns/100ps
interface ctm_fifo_if #(parameter int W = 8);
    logic wrValid;
    logic wrReady;
    logic [W-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [W-1:0] rdData;

    modport producer (
        output wrValid, wrData, rdReady,
        input wrReady, rdValid, rdData
    );
    modport buffer (
        input wrValid, wrData, rdReady,
        output wrReady, rdValid, rdData
    );
endinterface

// *** ctm_event_fifo.sv ***
`timescale 1ns/100ps
// depth must be a power of two so the pointers wrap for free
module ctm_event_fifo
    import ctm_pkg::*;
#(
    parameter int W = EVT_W,
    parameter int DEPTH = EVT_DEPTH
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // both sides
    ctm_fifo_if.buffer port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [W-1:0] outData;
        logic outValid;
    } ctm_fifo_st_t;

    ctm_fifo_st_t st_q;
    ctm_fifo_st_t st_d;
    logic push;
    logic pop;
    logic take;

    assign port.wrReady = (st_q.cnt != (AW+1)'(DEPTH));
    assign port.rdValid = st_q.outValid;
    assign port.rdData = st_q.outData;
    assign push = port.wrValid && port.wrReady;
    assign pop = st_q.outValid && port.rdReady;
    assign take = (!st_q.outValid || pop) && (st_q.cnt != '0);

    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wp] = port.wrData;
            st_d.wp = st_q.wp + 1'b1;
        end
        // the output word is a register, so a read never races a write
        if (take)
        begin
            st_d.outData = st_q.mem[st_q.rp];
            st_d.rp = st_q.rp + 1'b1;
            st_d.outValid = 1'b1;
        end
        else if (pop)
        begin
            st_d.outValid = 1'b0;
        end
        st_d.cnt = st_q.cnt + push - take;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_fifo_no_overfill: assert property (st_q.cnt <= (AW+1)'(DEPTH))
        else $error("event buffer count beyond depth");
    a_fifo_hold_word: assert property (
        st_q.outValid && !port.rdReady |=> st_q.outValid && $stable(st_q.outData))
        else $error("event word changed while stalled");
endmodule

// *** ctm_transceiver_ctrl.sv ***
`timescale 1ns/100ps
// Behaviour
// - transmit held dominant beyond timeout disables driver, bus goes recessive.
// - after timeout, driver stays off until a rising transmit edge.
// - standby_request low selects normal mode, driver and receiver enabled.
// - standby_request high selects standby: driver off, only low-power monitor.
// - floating standby_request reads high, giving standby.
// - floating transmit input reads high, i.e. recessive.
// - wake detector accepts a bus state only after it holds past wake_filter_time.
// - wake needs filtered dominant inside wake_window_time, else discarded.
// - recognised remote wake drives receive output low in standby.
// - in standby receive output stays high until a valid wake.
// - core supply low enters protected state, bus outputs high impedance.
// - single-supply recovery returns only after supply_recovery_delay.
// - dual-supply recovery returns only after mode_settle_delay.
// - either supply low, logic_supply on dual variant, forces protected mode.
// - over-temperature turns driver off, bus recessive, receive path still works.
// - thermal shutdown clears only when temperature falls past hysteresis.
// - normal mode drives bus from transmit input, receive output shows bus.
// - receive output low on dominant differential, high on recessive.
module ctm_transceiver_ctrl
    import ctm_pkg::*;
#(
    parameter bit DUAL_SUPPLY = 1'b0,
    parameter int DOM_CYC = DOM_TIMEOUT_CYC,
    parameter int WKF_CYC = WK_FILTER_CYC,
    parameter int WIN_CYC = WK_WINDOW_CYC,
    parameter int RECOV_CYC = RECOVERY_CYC,
    parameter int SETTLE_CYC = MODE_SETTLE_CYC,
    parameter int FIFO_W = EVT_W,
    parameter int FIFO_DEPTH = EVT_DEPTH
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // controller side pins
    input wire logic txdIn,
    input wire logic txdDriven,
    input wire logic standbyRequest,
    input wire logic stbDriven,
    output logic rxdOut,
    output logic rxdOe,
    // bus comparators
    input wire logic busDominant,
    input wire logic lpBusDominant,
    // bus driver controls
    output logic drvDominant,
    output logic drvEnable,
    output logic busPulldown,
    // supply and thermal monitors
    input wire logic coreSupplyLow,
    input wire logic logicSupplyLow,
    input wire logic overtempHigh,
    input wire logic tempBelowHyst,
    // status
    output logic modeNormal,
    output logic modeStandby,
    output logic modeProtected,
    output logic thermalShutdown,
    output logic domTimeout,
    output logic wakeFlag,
    // event stream
    output logic evtValid,
    input wire logic evtReady,
    output logic [FIFO_W-1:0] evtData,
    output logic evtSpace
);
    ctm_core_t st_q;
    ctm_core_t st_d;
    logic txdEff;
    logic stbEff;
    logic uvAny;
    logic filtTurn;
    logic wakeHit;
    logic [EV_BITS-1:0] evBits;
    logic [CNT_W-1:0] recLast;

    ctm_fifo_if #(.W(FIFO_W)) evq ();

    ctm_event_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_evq (
        .mclk(mclk),
        .rst(rst),
        .port(evq.buffer)
    );

    // internal pull-ups: an undriven pin reads high
    assign txdEff = txdDriven ? txdIn : 1'b1;
    assign stbEff = stbDriven ? standbyRequest : 1'b1;
    assign uvAny = coreSupplyLow || (DUAL_SUPPLY && logicSupplyLow);
    assign recLast = DUAL_SUPPLY ? CNT_W'(SETTLE_CYC - 1)
                                 : CNT_W'(RECOV_CYC - 1);

    always_comb
    begin
        st_d = st_q;
        evBits = '0;
        filtTurn = 1'b0;
        wakeHit = 1'b0;
        st_d.txdPrev = txdEff;

        // thermal flag with hysteresis; a new trip wins over the clear
        if (overtempHigh)
        begin
            st_d.tsd = 1'b1;
        end
        else if (tempBelowHyst)
        begin
            st_d.tsd = 1'b0;
        end
        if (overtempHigh && !st_q.tsd)
        begin
            evBits[EV_TSD] = 1'b1;
        end

        // dominant timeout: count consecutive dominant cycles in normal mode
        if (st_q.mode == ST_NORM && !txdEff)
        begin
            if (st_q.domCnt != CNT_W'(DOM_CYC))
            begin
                st_d.domCnt = st_q.domCnt + 1'b1;
            end
        end
        else
        begin
            st_d.domCnt = '0;
        end
        if (st_q.mode == ST_NORM && !txdEff && !st_q.domFault
            && st_q.domCnt == CNT_W'(DOM_CYC))
        begin
            st_d.domFault = 1'b1;
            evBits[EV_DOMTO] = 1'b1;
        end
        else if (txdEff && !st_q.txdPrev)
        begin
            st_d.domFault = 1'b0;
        end

        // wake filter on the low-power comparator, standby only
        if (st_q.mode != ST_STBY)
        begin
            st_d.filtDom = 1'b0;
            st_d.filtCnt = '0;
        end
        else if (lpBusDominant == st_q.filtDom)
        begin
            st_d.filtCnt = '0;
        end
        else if (st_q.filtCnt == CNT_W'(WKF_CYC))
        begin
            st_d.filtDom = lpBusDominant;
            st_d.filtCnt = '0;
            filtTurn = 1'b1;
        end
        else
        begin
            st_d.filtCnt = st_q.filtCnt + 1'b1;
        end

        // wake pattern: dominant, recessive, dominant, all inside the window
        if (st_q.mode != ST_STBY)
        begin
            st_d.wk = WK_IDLE;
            st_d.winCnt = '0;
        end
        else
        begin
            case (st_q.wk)
                WK_IDLE:
                begin
                    st_d.winCnt = '0;
                    if (filtTurn && lpBusDominant)
                    begin
                        st_d.wk = WK_DOM1;
                    end
                end
                WK_DOM1, WK_REC:
                begin
                    if (st_q.winCnt == CNT_W'(WIN_CYC))
                    begin
                        st_d.wk = WK_IDLE;
                    end
                    else
                    begin
                        st_d.winCnt = st_q.winCnt + 1'b1;
                        if (filtTurn && !lpBusDominant && st_q.wk == WK_DOM1)
                        begin
                            st_d.wk = WK_REC;
                        end
                        else if (filtTurn && lpBusDominant
                                 && st_q.wk == WK_REC)
                        begin
                            st_d.wk = WK_DONE;
                            wakeHit = 1'b1;
                        end
                    end
                end
                WK_DONE:
                begin
                    st_d.wk = WK_DONE;
                end
                default:
                begin
                    st_d.wk = WK_IDLE;
                end
            endcase
        end

        // wake latch: set only in standby, so it never meets the clear
        if (wakeHit)
        begin
            st_d.wakeSeen = 1'b1;
            evBits[EV_WAKE] = 1'b1;
        end
        else if (st_q.mode == ST_NORM)
        begin
            st_d.wakeSeen = 1'b0;
        end

        // mode selection
        case (st_q.mode)
            ST_PROT:
            begin
                if (!uvAny)
                begin
                    st_d.mode = ST_RECOV;
                    st_d.recCnt = '0;
                end
            end
            ST_RECOV:
            begin
                if (st_q.recCnt == recLast)
                begin
                    st_d.mode = stbEff ? ST_STBY : ST_NORM;
                    evBits[EV_READY] = 1'b1;
                end
                else
                begin
                    st_d.recCnt = st_q.recCnt + 1'b1;
                end
            end
            ST_STBY:
            begin
                if (!stbEff)
                begin
                    st_d.mode = ST_NORM;
                end
            end
            ST_NORM:
            begin
                if (stbEff)
                begin
                    st_d.mode = ST_STBY;
                end
            end
            default:
            begin
                st_d.mode = ST_PROT;
            end
        endcase
        // undervoltage overrides every other transition
        if (uvAny)
        begin
            st_d.mode = ST_PROT;
            if (st_q.mode != ST_PROT)
            begin
                evBits[EV_UV] = 1'b1;
            end
        end

        // registered pin data, one cycle behind the inputs
        st_d.drvDom = (st_d.mode == ST_NORM) && !st_d.tsd
                      && !st_d.domFault && !txdEff;
        case (st_d.mode)
            ST_NORM: st_d.rxd = !busDominant;
            ST_STBY: st_d.rxd = !st_d.wakeSeen;
            default: st_d.rxd = 1'b1;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_q <= '0;
            st_q.mode <= MODE_RESET;
            st_q.wk <= WK_IDLE;
            st_q.txdPrev <= 1'b1;
            st_q.rxd <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // events that find the buffer full are lost; evtSpace shows that risk
    assign evq.wrValid = |evBits;
    assign evq.wrData = FIFO_W'(evBits);
    assign evq.rdReady = evtReady;
    assign evtValid = evq.rdValid;
    assign evtData = evq.rdData;
    assign evtSpace = evq.wrReady;

    assign drvDominant = st_q.drvDom;
    // thermal shutdown keeps the recessive bias, so the driver stays enabled
    assign drvEnable = (st_q.mode == ST_NORM);
    assign busPulldown = (st_q.mode == ST_STBY)
                         || (st_q.mode == ST_PROT && !uvAny);
    assign rxdOut = st_q.rxd;
    assign rxdOe = !(st_q.mode == ST_PROT && DUAL_SUPPLY
                     && logicSupplyLow);
    assign modeNormal = (st_q.mode == ST_NORM);
    assign modeStandby = (st_q.mode == ST_STBY);
    assign modeProtected = (st_q.mode == ST_PROT);
    assign thermalShutdown = st_q.tsd;
    assign domTimeout = st_q.domFault;
    assign wakeFlag = st_q.wakeSeen;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_fault_low;
        st_q.domFault && !txdEff;
    endsequence
    sequence s_fault_rise;
        s_fault_low ##1 txdEff;
    endsequence
    sequence s_uv_gone;
        st_q.mode == ST_PROT && !uvAny;
    endsequence

    a_dom_trip: assert property (
        st_q.mode == ST_NORM && !uvAny && !stbEff && !txdEff
        && st_q.domCnt == CNT_W'(DOM_CYC) |=> st_q.domFault && !drvDominant)
        else $error("dominant timeout did not release the bus");
    a_dom_hold: assert property (s_fault_low |=> st_q.domFault)
        else $error("timeout fault cleared without a rising edge");
    a_dom_rearm: assert property (s_fault_rise |=> !st_q.domFault)
        else $error("rising edge did not re-enable the driver");
    a_norm_select: assert property (
        st_q.mode == ST_STBY && !stbEff && !uvAny |=> st_q.mode == ST_NORM)
        else $error("low standby_request did not select normal mode");
    a_stby_select: assert property (
        st_q.mode == ST_NORM && stbEff && !uvAny
        |=> st_q.mode == ST_STBY && !drvEnable && !drvDominant)
        else $error("standby entry left the driver on");
    a_filter_hold: assert property (
        st_q.mode == ST_STBY && st_q.filtCnt != CNT_W'(WKF_CYC)
        |=> st_q.mode != ST_STBY || $stable(st_q.filtDom))
        else $error("filtered bus state changed before the filter time");
    a_window_expire: assert property (
        st_q.mode == ST_STBY && st_q.wk inside {WK_DOM1, WK_REC}
        && st_q.winCnt == CNT_W'(WIN_CYC)
        |=> st_q.wk == WK_IDLE && $stable(st_q.wakeSeen))
        else $error("wake accepted after the window expired");
    a_wake_rxd_low: assert property (
        st_q.mode == ST_STBY && st_q.wakeSeen |-> !rxdOut)
        else $error("recognised wake not shown low on receive output");
    a_stby_rxd_high: assert property (
        st_q.mode == ST_STBY && !st_q.wakeSeen |-> rxdOut)
        else $error("receive output low in standby without a wake");
    a_uv_enter: assert property (
        uvAny |=> st_q.mode == ST_PROT ##0 !drvEnable && !drvDominant)
        else $error("undervoltage did not enter protected mode");
    a_recov_start: assert property (s_uv_gone |=> st_q.mode == ST_RECOV)
        else $error("recovery delay skipped after undervoltage");
    a_recov_wait: assert property (
        st_q.mode == ST_RECOV && st_q.recCnt != recLast && !uvAny
        |=> st_q.mode == ST_RECOV)
        else $error("left recovery before the delay elapsed");
    a_tsd_off: assert property (st_q.tsd |-> !drvDominant)
        else $error("driver dominant during thermal shutdown");
    a_tsd_hyst: assert property (
        st_q.tsd && !tempBelowHyst |=> st_q.tsd)
        else $error("thermal shutdown cleared above hysteresis point");
    a_norm_mirror: assert property (
        st_q.mode == ST_NORM && $past(st_q.mode) == ST_NORM
        |-> rxdOut == !$past(busDominant))
        else $error("receive output does not mirror the bus");
    a_wake_clear: assert property (
        st_q.mode == ST_NORM |=> st_q.mode != ST_NORM || !st_q.wakeSeen)
        else $error("wake indication survived into normal mode");
endmodule

// *** ctm_ctrl_model.sv ***
`timescale 1ns/100ps
module ctm_ctrl_model
(
    // clock
    input wire logic mclk,
    // commands from the bench
    input wire logic reqTxd,
    input wire logic reqStb,
    input wire logic floatTxd,
    input wire logic floatStb,
    input wire logic wakeAnswer,
    // transceiver side
    input wire logic rxdOut,
    input wire logic modeNormal,
    input wire logic modeStandby,
    output logic txdIn,
    output logic txdDriven,
    output logic standbyRequest,
    output logic stbDriven
);
    logic woke = 1'b0;
    // a released pin shows the unsafe level so only the pull-up saves it
    assign txdDriven = !floatTxd;
    assign stbDriven = !floatStb;
    // no traffic until recovery is over; long lows only on command
    assign txdIn = floatTxd ? 1'b0 : (reqTxd || !modeNormal);
    assign standbyRequest = floatStb ? 1'b0 : (reqStb && !woke);
    // a low receive output in standby is answered by asking for normal
    // sampled on the rising edge so the bench's falling-edge drive never races
    always @(posedge mclk)
        woke <= wakeAnswer && (woke || (modeStandby && !rxdOut));
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb
    import ctm_pkg::*;
;
    localparam int DOM = 20;
    localparam int WKF = 3;
    localparam int WIN = 60;
    localparam int REC = 8;
    logic mclk = 0, rst = 1, busDominant = 0, lpBusDominant = 0;
    logic coreSupplyLow = 0, logicSupplyLow = 0;
    logic overtempHigh = 0, tempBelowHyst = 1, evtReady = 0;
    logic reqTxd = 1, reqStb = 1, floatTxd = 0, floatStb = 1;
    logic wakeAnswer = 0;
    logic txdIn, txdDriven, standbyRequest, stbDriven, rxdOut, rxdOe;
    logic drvDominant, drvEnable, busPulldown, modeNormal, modeStandby;
    logic modeProtected, thermalShutdown, domTimeout, wakeFlag;
    logic evtValid, evtSpace;
    logic rxdOe2, modeNormal2, modeProtected2;
    logic [7:0] evtData;
    logic [7:0] rnd = 8'h5d;
    int nFail = 0, checkCount = 0, n;

    always #5 mclk = !mclk;

    ctm_ctrl_model partner (.mclk(mclk), .reqTxd(reqTxd), .reqStb(reqStb),
        .floatTxd(floatTxd), .floatStb(floatStb), .wakeAnswer(wakeAnswer),
        .rxdOut(rxdOut), .modeNormal(modeNormal), .modeStandby(modeStandby),
        .txdIn(txdIn), .txdDriven(txdDriven),
        .standbyRequest(standbyRequest), .stbDriven(stbDriven));

    ctm_transceiver_ctrl #(.DOM_CYC(DOM), .WKF_CYC(WKF), .WIN_CYC(WIN),
        .RECOV_CYC(REC), .SETTLE_CYC(5)) dut (.mclk(mclk), .rst(rst),
        .txdIn(txdIn), .txdDriven(txdDriven),
        .standbyRequest(standbyRequest), .stbDriven(stbDriven),
        .rxdOut(rxdOut), .rxdOe(rxdOe), .busDominant(busDominant),
        .lpBusDominant(lpBusDominant), .drvDominant(drvDominant),
        .drvEnable(drvEnable), .busPulldown(busPulldown),
        .coreSupplyLow(coreSupplyLow), .logicSupplyLow(logicSupplyLow),
        .overtempHigh(overtempHigh), .tempBelowHyst(tempBelowHyst),
        .modeNormal(modeNormal), .modeStandby(modeStandby),
        .modeProtected(modeProtected), .thermalShutdown(thermalShutdown),
        .domTimeout(domTimeout), .wakeFlag(wakeFlag), .evtValid(evtValid),
        .evtReady(evtReady), .evtData(evtData), .evtSpace(evtSpace));

    // dual-supply variant on the same stimulus, for the logic supply checks
    ctm_transceiver_ctrl #(.DUAL_SUPPLY(1'b1), .DOM_CYC(DOM), .WKF_CYC(WKF),
        .WIN_CYC(WIN), .RECOV_CYC(REC), .SETTLE_CYC(5)) dutDual (.mclk(mclk),
        .rst(rst), .txdIn(txdIn), .txdDriven(txdDriven),
        .standbyRequest(standbyRequest), .stbDriven(stbDriven),
        .rxdOut(), .rxdOe(rxdOe2), .busDominant(busDominant),
        .lpBusDominant(lpBusDominant), .drvDominant(), .drvEnable(),
        .busPulldown(), .coreSupplyLow(coreSupplyLow),
        .logicSupplyLow(logicSupplyLow), .overtempHigh(overtempHigh),
        .tempBelowHyst(tempBelowHyst), .modeNormal(modeNormal2),
        .modeStandby(), .modeProtected(modeProtected2),
        .thermalShutdown(), .domTimeout(), .wakeFlag(), .evtValid(),
        .evtReady(evtReady), .evtData(), .evtSpace());

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            nFail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task complete_run;
        if (nFail == 0 && checkCount > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    // receive output must stay high while no wake is complete
    task lp(input logic v, input int k);
        lpBusDominant = v;
        repeat (k)
        begin
            cyc(1);
            check("standby rxd", rxdOut, 8'h1);
        end
    endtask

    task wait_normal;
        n = 0;
        while (modeNormal !== 1'b1)
        begin
            if (n++ == 40)
            begin
                nFail++;
                complete_run;
            end
            cyc(1);
        end
    endtask

    initial
    begin
        cyc(20000);
        nFail++;
        complete_run;
    end

    initial
    begin
        cyc(1);
        check("reset rxd", rxdOut, 8'h1);
        check("reset drive", drvEnable, 8'h0);
        check("reset space", evtSpace, 8'h1);
        cyc(2);
        rst = 0;
        cyc(REC - 2);
        check("early mode", {modeNormal, modeStandby}, 8'h0);
        cyc(6);
        check("float stb", modeStandby, 8'h1);
        check("standby drive", drvEnable, 8'h0);
        check("pulldown", busPulldown, 8'h1);
        floatStb = 0;
        busDominant = 1;
        // short glitch, then a pattern too slow for the window
        lp(1, WKF);
        lp(0, 6);
        lp(1, WKF + 2);
        lp(0, WIN + 10);
        lp(1, WKF + 2);
        lp(0, WKF + 2);
        lpBusDominant = 1;
        cyc(WKF + 4);
        check("wake rxd", rxdOut, 8'h0);
        check("wake flag", wakeFlag, 8'h1);
        lpBusDominant = 0;
        busDominant = 0;
        cyc(5);
        check("wake held", rxdOut, 8'h0);
        wakeAnswer = 1;
        wait_normal;
        reqStb = 0;
        wakeAnswer = 0;
        cyc(2);
        check("wake clear", wakeFlag, 8'h0);
        check("normal drive", drvEnable, 8'h1);
        for (int i = 0; i < 200; i++)
        begin
            rnd = lfsr(rnd);
            reqTxd = rnd[0] | rnd[1];
            busDominant = rnd[2];
            cyc(1);
            check("drv follows txd", drvDominant, !reqTxd);
            check("rxd mirrors bus", rxdOut, !busDominant);
        end
        reqTxd = 1;
        floatTxd = 1;
        cyc(3);
        check("float txd", drvDominant, 8'h0);
        floatTxd = 0;
        reqTxd = 0;
        cyc(DOM);
        check("long dominant", drvDominant, 8'h1);
        cyc(3);
        check("timeout drv", drvDominant, 8'h0);
        check("timeout flag", domTimeout, 8'h1);
        cyc(10);
        check("still off", drvDominant, 8'h0);
        reqTxd = 1;
        cyc(1);
        reqTxd = 0;
        cyc(2);
        check("re-enabled", drvDominant, 8'h1);
        check("fault gone", domTimeout, 8'h0);
        overtempHigh = 1;
        tempBelowHyst = 0;
        busDominant = 1;
        cyc(3);
        check("thermal", thermalShutdown, 8'h1);
        check("thermal drv", drvDominant, 8'h0);
        check("thermal bias", drvEnable, 8'h1);
        check("thermal rxd", rxdOut, 8'h0);
        reqTxd = 1;
        overtempHigh = 0;
        busDominant = 0;
        cyc(3);
        check("hysteresis", thermalShutdown, 8'h1);
        tempBelowHyst = 1;
        cyc(2);
        check("thermal clear", thermalShutdown, 8'h0);
        coreSupplyLow = 1;
        cyc(2);
        check("protected", modeProtected, 8'h1);
        check("bus released", drvEnable, 8'h0);
        coreSupplyLow = 0;
        cyc(REC - 1);
        check("recovering", modeNormal, 8'h0);
        wait_normal;
        logicSupplyLow = 1;
        cyc(2);
        check("logic uv", {modeProtected2, rxdOe2, modeProtected, rxdOe},
            8'h9);
        logicSupplyLow = 0;
        cyc(4);
        check("settling", modeNormal2, 8'h0);
        cyc(2);
        check("settled", modeNormal2, 8'h1);
        evtReady = 1;
        cyc(40);
        evtReady = 0;
        repeat (20)
        begin
            overtempHigh = 1;
            tempBelowHyst = 0;
            cyc(1);
            overtempHigh = 0;
            tempBelowHyst = 1;
            cyc(2);
        end
        check("buffer full", evtSpace, 8'h0);
        n = 0;
        repeat (100)
        begin
            rnd = lfsr(rnd);
            evtReady = rnd[0];
            if (evtValid === 1'b1 && evtReady)
            begin
                n++;
                check("event word", evtData, 8'h1 << EV_TSD);
            end
            cyc(1);
        end
        check("words drained", n[7:0], 8'h11);
        check("buffer empty", evtValid, 8'h0);
        complete_run;
    end
endmodule
